//--- rtl/aes_tx_pkg.sv
// Constants shared by the transmitter and its serial audio input port.
// Assumes a 25 MHz system clock acting as the transmit master clock.
package aes_tx_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_NS = 40;
  localparam int HALF_CELL_NS = 80;
  localparam int HALF_DIV = (HALF_CELL_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // ----------------------------------------------------------------
  // Sample and input port layout
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 24;
  localparam int SHIFT_W = 32;
  localparam logic [5:0] SAMPLE_BITS = 6'h18;
  localparam logic [5:0] CNT_MAX = 6'h20;
  localparam logic [1:0] RES_24 = 2'h0;
  localparam logic [1:0] RES_20 = 2'h1;
  localparam logic [1:0] RES_16 = 2'h2;
  localparam logic [1:0] RES_18 = 2'h3;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int CS_BYTES = 24;
  localparam logic [7:0] FRAMES_LAST = 8'hbf;
  localparam logic [7:0] CRC_FIRST = 8'hb8;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h1d;
  localparam logic [7:0] PRE_X = 8'he2;
  localparam logic [7:0] PRE_Y = 8'he4;
  localparam logic [7:0] PRE_Z = 8'he8;
  localparam logic [4:0] SLOT_AUDIO = 5'h04;
  localparam logic [4:0] SLOT_V = 5'h1c;
  localparam logic [4:0] SLOT_U = 5'h1d;
  localparam logic [4:0] SLOT_C = 5'h1e;
  localparam logic [4:0] SLOT_P = 5'h1f;

  typedef enum logic [1:0] {
    TX_OFF = 2'b01,
    TX_RUN = 2'b10
  } tx_state_e;
endpackage : aes_tx_pkg

//--- rtl/port_sync.sv
// Three-stage synchroniser with agreement filter for signals from
// another clock domain. Assumes each bit changes slowly.
`timescale 1ns/10ps
module port_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Foreign and filtered levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, agree;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once stages two and three agree
  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q <= '0;
    end else begin
      out_q <= (agree & s3_q) | (~agree & out_q);
    end
  end

  assign sync_out = out_q;
endmodule : port_sync

//--- rtl/aes3_tx_with_serial_audio_in.sv
// Serial audio input port feeding a biphase-mark line transmitter.
// Assumes sys_clk is the transmit master clock and the port bit clock
// is a separate, possibly stopping domain; port settings are static.
//
// Notes on behaviour
// - Master mode drives both port clocks
// - Master/slave, clock rate, resolution configurable
// - Justify select: 0 left, 1 right
// - Optional one-bit-clock first-bit delay
// - Programmable bit clock, word select polarity
// - I2S takes any bit count
// - Mux audio, C, U, V; biphase-mark encode
// - Encoder runs from master clock only
// - Slip flag on dropped or repeated sample
// - C and U from internal storage
// - User bits optionally from pin
// - Line low on reset, no clock, disable
// - Mute replaces audio with silence
// - Host fills one-block C and U buffers
// - Stand-alone takes C and U from pins
`timescale 1ns/10ps
module aes3_tx_with_serial_audio_in
  import aes_tx_pkg::*;
#(
  parameter int DIV = HALF_DIV
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Serial audio port pins
  input wire logic port_bit_clock,
  output logic port_bit_clock_out,
  output logic port_bit_clock_oe,
  input wire logic port_word_select,
  output logic port_word_select_out,
  output logic port_word_select_oe,
  input wire logic port_serial_data_in,
  // Port configuration
  input wire logic port_master_select,
  input wire logic port_bit_clock_rate,
  input wire logic [1:0] port_resolution_field,
  input wire logic port_justify_select,
  input wire logic port_first_bit_delay,
  input wire logic port_bit_clock_polarity,
  input wire logic port_word_select_polarity,
  // Transmitter control
  input wire logic output_disable,
  input wire logic mute_audio,
  input wire logic validity_bit,
  input wire logic user_from_pin,
  input wire logic standalone_mode,
  input wire logic tx_clock_valid,
  input wire logic slip_clear,
  // Channel status and user buffer writes
  input wire logic cs_wr_en,
  input wire logic user_wr_en,
  input wire logic [4:0] buf_wr_addr,
  input wire logic [7:0] buf_wr_data,
  // Stand-alone C and U pins
  input wire logic cs_pin,
  input wire logic user_pin,
  // Line and status outputs
  output logic line_out_pos,
  output logic line_out_neg,
  output logic sample_slip_flag
);
  // ----------------------------------------------------------------
  // Link domain: capture on the active bit clock edge
  // ----------------------------------------------------------------
  logic lclk, lr, sd;
  logic prev_q, tog_q, chan_q;
  logic [SHIFT_W-1:0] sh_q, fin_sh;
  logic [5:0] cnt_q, fin_cnt;
  logic [SAMPLE_W-1:0] word_q;

  assign lclk = port_bit_clock ^ port_bit_clock_polarity;
  assign lr = port_word_select ^ port_word_select_polarity;
  assign sd = port_serial_data_in;

  function automatic logic [5:0] res_bits(input logic [1:0] r);
    case (r)
      RES_20: return 6'h14;
      RES_16: return 6'h10;
      RES_18: return 6'h12;
      default: return SAMPLE_BITS;
    endcase
  endfunction : res_bits

  // Left justify the captured word into a full-width sample
  function automatic logic [SAMPLE_W-1:0] align(
    input logic [SHIFT_W-1:0] s, input logic [5:0] n,
    input logic rj, input logic [1:0] r);
    logic [5:0] keep;
    logic [SHIFT_W-1:0] w;
    keep = rj ? res_bits(r) : n;
    if (keep > SAMPLE_BITS) begin
      w = s >> (keep - SAMPLE_BITS);
    end else begin
      w = s << (SAMPLE_BITS - keep);
    end
    return w[SAMPLE_W-1:0];
  endfunction : align

  always_comb begin
    fin_sh = sh_q;
    fin_cnt = cnt_q;
    if (port_first_bit_delay &&
        (port_justify_select || cnt_q != CNT_MAX)) begin
      fin_sh = {sh_q[SHIFT_W-2:0], sd};
      fin_cnt = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 6'h01;
    end
  end

  always_ff @(posedge lclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
      sh_q <= '0;
      cnt_q <= '0;
    end else begin
      prev_q <= lr;
      if (lr != prev_q) begin
        if (port_first_bit_delay) begin
          sh_q <= '0;
          cnt_q <= '0;
        end else begin
          sh_q <= {{(SHIFT_W-1){1'b0}}, sd};
          cnt_q <= 6'h01;
        end
      end else if (port_justify_select || cnt_q != CNT_MAX) begin
        sh_q <= {sh_q[SHIFT_W-2:0], sd};
        if (cnt_q != CNT_MAX) begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end

  // Word is held until the next phase ends; toggle marks a new one
  always_ff @(posedge lclk or posedge sys_rst) begin
    if (sys_rst) begin
      word_q <= '0;
      chan_q <= 1'b0;
      tog_q <= 1'b0;
    end else if (lr != prev_q) begin
      word_q <= align(fin_sh, fin_cnt, port_justify_select,
                      port_resolution_field);
      chan_q <= prev_q;
      tog_q <= ~tog_q;
    end
  end

  // ----------------------------------------------------------------
  // Crossings into the master clock domain
  // ----------------------------------------------------------------
  logic tog_s, tog_seen_q, word_evt, clk_ok_s, c_pin_s, u_pin_s;

  port_sync #(.WIDTH(1)) u_tog_sync (
    .clk(sys_clk),
    .rst(sys_rst),
    .async_in(tog_q),
    .sync_out(tog_s)
  );

  port_sync #(.WIDTH(3)) u_pin_sync (
    .clk(sys_clk),
    .rst(sys_rst),
    .async_in({tx_clock_valid, cs_pin, user_pin}),
    .sync_out({clk_ok_s, c_pin_s, u_pin_s})
  );

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tog_seen_q <= 1'b0;
    end else begin
      tog_seen_q <= tog_s;
    end
  end

  // Word and channel are stable for a whole phase once seen here
  assign word_evt = tog_s != tog_seen_q;

  // ----------------------------------------------------------------
  // Transmit timing
  // ----------------------------------------------------------------
  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
  tx_state_e state_q, state_d;
  logic [7:0] dv_q;
  logic [6:0] hc_q, hn;
  logic [4:0] slot;
  logic tick, half, fstart, sstart, run;

  always_comb begin
    case (state_q)
      TX_OFF: state_d = clk_ok_s ? TX_RUN : TX_OFF;
      TX_RUN: state_d = clk_ok_s ? TX_RUN : TX_OFF;
      default: state_d = TX_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= TX_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  assign run = state_q == TX_RUN;
  assign tick = run && dv_q == DIV_LAST;
  assign hn = hc_q + 7'h01;
  assign slot = hn[5:1];
  assign half = hn[0];
  assign sstart = tick && hn[5:0] == 6'h00;
  assign fstart = sstart && !hn[6];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dv_q <= '0;
      hc_q <= 7'h7f;
    end else if (!run) begin
      dv_q <= '0;
      hc_q <= 7'h7f;
    end else begin
      dv_q <= tick ? 8'h00 : dv_q + 8'h01;
      if (tick) begin
        hc_q <= hn;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_bit_clock_out <= 1'b0;
      port_word_select_out <= 1'b0;
      port_bit_clock_oe <= 1'b0;
      port_word_select_oe <= 1'b0;
    end else begin
      port_bit_clock_out <= port_bit_clock_rate ? hc_q[1] : hc_q[0];
      port_word_select_out <= ~hc_q[6] ^ port_word_select_polarity;
      port_bit_clock_oe <= port_master_select;
      port_word_select_oe <= port_master_select;
    end
  end

  // ----------------------------------------------------------------
  // Sample pairing and slip detection
  // ----------------------------------------------------------------
  logic [SAMPLE_W-1:0] hold_l_q, pend_l_q, pend_r_q, smp_l_q, smp_r_q;
  logic pend_v_q, pair_in, slip_evt, slip_q;

  assign pair_in = word_evt && !chan_q;
  assign slip_evt = (pair_in && pend_v_q && !fstart) ||
                    (fstart && !pend_v_q);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_l_q <= '0;
      pend_l_q <= '0;
      pend_r_q <= '0;
      pend_v_q <= 1'b0;
    end else begin
      if (word_evt && chan_q) begin
        hold_l_q <= word_q;
      end
      // A pair landing with the frame start stays pending
      if (pair_in) begin
        pend_l_q <= hold_l_q;
        pend_r_q <= word_q;
        pend_v_q <= 1'b1;
      end else if (fstart) begin
        pend_v_q <= 1'b0;
      end
    end
  end

  // Set wins over software clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slip_q <= 1'b0;
    end else if (slip_evt) begin
      slip_q <= 1'b1;
    end else if (slip_clear) begin
      slip_q <= 1'b0;
    end
  end

  assign sample_slip_flag = slip_q;

  // ----------------------------------------------------------------
  // Channel status and user storage
  // ----------------------------------------------------------------
  logic [7:0] cs_mem [CS_BYTES];
  logic [7:0] u_mem [CS_BYTES];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < CS_BYTES; i++) begin
        cs_mem[i] <= 8'h00;
        u_mem[i] <= 8'h00;
      end
    end else if (buf_wr_addr < 5'(CS_BYTES)) begin
      if (cs_wr_en) begin
        cs_mem[buf_wr_addr] <= buf_wr_data;
      end
      if (user_wr_en) begin
        u_mem[buf_wr_addr] <= buf_wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame data selection
  // ----------------------------------------------------------------
  logic [7:0] fr_q, fr_n, fr_cur, crc_q, pre_pat;
  logic c_mem_bit, c_next, u_next, c_bit_q, u_bit_q, crc_fb;

  assign fr_n = (fr_q == FRAMES_LAST) ? 8'h00 : fr_q + 8'h01;
  assign fr_cur = (hn == 7'h00) ? fr_n : fr_q;
  assign c_mem_bit = cs_mem[fr_n[7:3]][fr_n[2:0]];

  always_comb begin
    if (standalone_mode) begin
      c_next = c_pin_s;
    end else if (fr_n >= CRC_FIRST) begin
      c_next = crc_q[fr_n[2:0]];
    end else begin
      c_next = c_mem_bit;
    end
    if (user_from_pin || standalone_mode) begin
      u_next = u_pin_s;
    end else begin
      u_next = u_mem[fr_n[7:3]][fr_n[2:0]];
    end
  end

  assign crc_fb = c_mem_bit ^ (fr_n == 8'h00 ? CRC_INIT[7] : crc_q[7]);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fr_q <= FRAMES_LAST;
      crc_q <= CRC_INIT;
      c_bit_q <= 1'b0;
      u_bit_q <= 1'b0;
      smp_l_q <= '0;
      smp_r_q <= '0;
    end else if (fstart) begin
      fr_q <= fr_n;
      c_bit_q <= c_next;
      u_bit_q <= u_next;
      smp_l_q <= pend_l_q;
      smp_r_q <= pend_r_q;
      if (fr_n == 8'h00) begin
        crc_q <= {CRC_INIT[6:0], 1'b0} ^ (crc_fb ? CRC_POLY : 8'h00);
      end else if (fr_n < CRC_FIRST) begin
        crc_q <= {crc_q[6:0], 1'b0} ^ (crc_fb ? CRC_POLY : 8'h00);
      end
    end
  end

  // ----------------------------------------------------------------
  // Biphase-mark encoder
  // ----------------------------------------------------------------
  logic [SAMPLE_W-1:0] smp_cur;
  logic [4:0] aidx;
  logic [2:0] pidx;
  logic bitv, nxt, lvl_q, base_q, par_q;

  assign pre_pat = hn[6] ? PRE_Y : (fr_cur == 8'h00 ? PRE_Z : PRE_X);
  assign pidx = 3'h7 - {slot[1:0], half};
  assign smp_cur = hn[6] ? smp_r_q : smp_l_q;
  assign aidx = slot - SLOT_AUDIO;

  always_comb begin
    case (slot)
      SLOT_V: bitv = validity_bit;
      SLOT_U: bitv = u_bit_q;
      SLOT_C: bitv = c_bit_q;
      SLOT_P: bitv = par_q;
      default: begin
        bitv = (slot >= SLOT_AUDIO) && !mute_audio && smp_cur[aidx];
      end
    endcase
  end

  always_comb begin
    if (slot < SLOT_AUDIO) begin
      nxt = pre_pat[pidx] ^ (sstart ? lvl_q : base_q);
    end else if (!half) begin
      nxt = ~lvl_q;
    end else begin
      nxt = lvl_q ^ bitv;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lvl_q <= 1'b0;
      base_q <= 1'b0;
      par_q <= 1'b0;
    end else if (tick) begin
      lvl_q <= nxt;
      if (sstart) begin
        base_q <= lvl_q;
        par_q <= 1'b0;
      end else if (!half && slot >= SLOT_AUDIO && slot < SLOT_P) begin
        par_q <= par_q ^ bitv;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_out_pos <= 1'b0;
      line_out_neg <= 1'b0;
    end else begin
      line_out_pos <= run && !output_disable && lvl_q;
      line_out_neg <= run && !output_disable && !lvl_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  line_quiet_a: assert property (
    output_disable |=> !line_out_pos && !line_out_neg)
    else $error("line driven while disabled");

  no_clock_a: assert property (
    !clk_ok_s |-> ##2 (!line_out_pos && !line_out_neg))
    else $error("line driven without transmit clock");

  line_diff_a: assert property (
    (run && !output_disable) |=> (line_out_pos != line_out_neg))
    else $error("line outputs not complementary");

  mute_zero_a: assert property (
    (mute_audio && slot >= SLOT_AUDIO && slot < SLOT_V) |-> !bitv)
    else $error("audio bit set while muted");

  slip_set_a: assert property (
    slip_evt |=> sample_slip_flag)
    else $error("slip not flagged");

  master_oe_a: assert property (
    ##1 (port_bit_clock_oe == $past(port_master_select)) &&
    (port_word_select_oe == $past(port_master_select)))
    else $error("port clock enables not following master select");

  parity_even_a: assert property (
    sstart |-> lvl_q == base_q)
    else $error("subframe ended with odd parity");

  frame_wrap_a: assert property (
    (fstart && fr_q == FRAMES_LAST) |=> fr_q == 8'h00)
    else $error("block did not wrap after last frame");

  user_pin_a: assert property (
    (fstart && user_from_pin) |=> u_bit_q == $past(u_pin_s))
    else $error("user bit not taken from pin");

  cs_store_a: assert property (
    (fstart && !standalone_mode && fr_n < CRC_FIRST) |=>
    c_bit_q == $past(c_mem_bit))
    else $error("channel status bit not from storage");

  slip_seen_c: cover property (slip_evt ##1 slip_clear);
  block_start_c: cover property (fstart && fr_n == 8'h00);
  pair_taken_c: cover property (pair_in ##[1:300] fstart);
endmodule : aes3_tx_with_serial_audio_in

//--- verif/audio_source.sv
// Serial audio source: sends fixed left and right words, left-justified,
// MSB first. Assumes the port is a slave capturing on the rising edge.
`timescale 1ns/10ps
module audio_source (
  // Master clock and enable
  input wire logic sys_clk,
  input wire logic run,
  // Words to send
  input wire logic [31:0] left_word,
  input wire logic [31:0] right_word,
  // Port pins
  output logic bit_clock,
  output logic word_select,
  output logic serial_data
);
  logic [31:0] w;

  initial begin
    bit_clock = 1'b0;
    word_select = 1'b1;
    serial_data = 1'b0;
    forever begin
      for (int ph = 0; ph < 2; ph++) begin
        @(negedge sys_clk);
        word_select = (ph == 0);
        w = ph == 0 ? left_word : right_word;
        #13;
        for (int i = 31; i >= 0; i--) begin
          serial_data = w[i];
          #40 bit_clock = run;
          #40 bit_clock = 1'b0;
        end
        // Hold time is over: show a changed level, never a stale one
        serial_data = ~serial_data;
        // Pads each phase to 128 master clocks, one pair per frame
        #2520;
      end
    end
  end
endmodule : audio_source

//--- verif/tb_top.sv
// Bench for the transmitter: a source model feeds the port in slave
// mode and the line is decoded from a ring of falling-edge samples.
// Assumes DIV of 2, so one frame spans 256 falling clock edges.
`timescale 1ns/10ps
module tb_top;
  import aes_tx_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, src_run = 1'b1, ms = 1'b0;
  logic rate = 1'b0, dis = 1'b0, mute = 1'b0, vbit = 1'b1, clr = 1'b0;
  logic upin_sel = 1'b0, alone = 1'b0, clk_ok = 1'b1, cs_pin = 1'b0;
  logic user_pin = 1'b0, cs_we = 1'b0, u_we = 1'b0;
  logic ws_pol = 1'b0, just = 1'b0, dly = 1'b0;
  logic src_bclk, src_ws, sdata, slip, bclk_out, bclk_oe, ws_out, ws_oe;
  logic line_out_pos, line_out_neg;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic [31:0] lw = 32'h89abcdef, rw = 32'h13572468;
  logic [7:0] cs_b [0:23], u_b [0:23];
  logic hb [0:8191];
  int nc = 0, zn = 0, mismatches = 0, num_checks = 0;
  wire logic bclk_pin = bclk_oe ? bclk_out : src_bclk;
  wire logic ws_pin = ws_oe ? ws_out : src_ws;

  aes3_tx_with_serial_audio_in #(.DIV(2)) aes3_tx_with_serial_audio_in_i (
    .sys_clk, .sys_rst, .port_bit_clock(bclk_pin),
    .port_bit_clock_out(bclk_out), .port_bit_clock_oe(bclk_oe),
    .port_word_select(ws_pin), .port_word_select_out(ws_out),
    .port_word_select_oe(ws_oe), .port_serial_data_in(sdata),
    .port_master_select(ms), .port_bit_clock_rate(rate),
    .port_resolution_field(2'h0), .port_justify_select(just),
    .port_first_bit_delay(dly), .port_bit_clock_polarity(1'b0),
    .port_word_select_polarity(ws_pol), .output_disable(dis),
    .mute_audio(mute), .validity_bit(vbit), .user_from_pin(upin_sel),
    .standalone_mode(alone), .tx_clock_valid(clk_ok), .slip_clear(clr),
    .cs_wr_en(cs_we), .user_wr_en(u_we), .buf_wr_addr(addr),
    .buf_wr_data(wdata), .cs_pin, .user_pin, .line_out_pos,
    .line_out_neg, .sample_slip_flag(slip));

  audio_source audio_source_i (.sys_clk, .run(src_run), .left_word(lw),
    .right_word(rw), .bit_clock(src_bclk), .word_select(src_ws),
    .serial_data(sdata));

  always #20 sys_clk = ~sys_clk;

  // Both samples of a half-cell are kept, so any phase decodes
  always @(negedge sys_clk) begin
    hb[nc % 8192] = line_out_pos;
    nc++;
  end

  // ----------------------------------------------------------------
  // Checking tasks
  // ----------------------------------------------------------------
  function automatic logic b(input int n);
    return hb[n % 8192];
  endfunction : b

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic cs, input int k, input logic [7:0] d);
    @(negedge sys_clk);
    cs_we = cs;
    u_we = ~cs;
    addr = k[4:0];
    wdata = d;
    @(negedge sys_clk);
    cs_we = 1'b0;
    u_we = 1'b0;
    if (k < 24 && cs) cs_b[k] = d;
    if (k < 24 && !cs) u_b[k] = d;
  endtask : wr

  task automatic find_z();
    logic [7:0] p;
    for (int k = 0; k < 60000; k++) begin
      @(posedge sys_clk);
      for (int i = 0; i < 8; i++) p[7 - i] = b(nc - 16 + 2 * i) ^ b(nc - 18);
      if (p === PRE_Z) begin
        zn = nc - 16;
        return;
      end
    end
    check("block start", 1'b0, 1'b1);
    report_and_stop();
  endtask : find_z

  // Decodes nf frames, starting three frames ahead to let inputs settle
  task automatic chk_frames(input int nf, input logic [23:0] ea, eb);
    int f, st, fi;
    logic [7:0] pre;
    logic [31:0] sl;
    f = (nc - zn) / 256 + 3;
    while (nc < zn + 256 * (f + nf) + 8) @(posedge sys_clk);
    for (int s = 0; s < 2 * nf; s++) begin
      st = zn + 256 * f + 128 * s;
      fi = (f + s / 2) % 192;
      for (int i = 0; i < 8; i++) pre[7 - i] = b(st + 2 * i) ^ b(st - 2);
      for (int j = 0; j < 32; j++) sl[j] = b(st + 4 * j) ^ b(st + 4 * j + 2);
      check("preamble", pre, s % 2 ? PRE_Y : fi == 0 ? PRE_Z : PRE_X);
      check("audio", sl[27:4], s % 2 ? eb : ea);
      check("validity", sl[SLOT_V], vbit);
      check("user", sl[SLOT_U], alone || upin_sel ? user_pin :
            u_b[fi / 8][fi % 8]);
      if (alone || fi < CRC_FIRST)
        check("status", sl[SLOT_C],
              alone ? cs_pin : cs_b[fi / 8][fi % 8]);
      check("parity", ^sl[31:4], 1'b0);
    end
    @(negedge sys_clk);
  endtask : chk_frames

  task automatic low_for(input string what);
    logic any;
    any = 1'b0;
    repeat (300) begin
      @(negedge sys_clk);
      any = any | line_out_pos | line_out_neg;
    end
    check(what, any, 1'b0);
  endtask : low_for

  task automatic s_master(input logic r, input int eb);
    int nb, nw;
    logic pb, pw;
    ms = 1'b1;
    rate = r;
    repeat (20) @(negedge sys_clk);
    nb = 0;
    nw = 0;
    pb = bclk_out;
    pw = ws_out;
    repeat (256) begin
      @(negedge sys_clk);
      nb += int'(bclk_out !== pb);
      nw += int'(ws_out !== pw);
      pb = bclk_out;
      pw = ws_out;
    end
    check("bit clock edges", nb, eb);
    check("word select edges", nw, 2);
    check("clock enables", {bclk_oe, ws_oe}, 2'h3);
    ms = 1'b0;
  endtask : s_master

  task automatic s_slip();
    int t;
    src_run = 1'b0;
    repeat (800) @(negedge sys_clk);
    check("slip set", slip, 1'b1);
    // Clear in mid-frame, away from any frame start
    t = zn + 256 * ((nc - zn) / 256 + 1) + 128;
    while (nc < t) @(negedge sys_clk);
    clr = 1'b1;
    @(negedge sys_clk);
    clr = 1'b0;
    @(negedge sys_clk);
    check("slip cleared", slip, 1'b0);
    src_run = 1'b1;
  endtask : s_slip

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    check("reset line", {line_out_pos, line_out_neg}, 2'h0);
    sys_rst = 1'b0;
    // Out-of-range writes come last, so a wrapped address would show
    for (int k = 0; k < 26; k++) begin
      wr(1'b1, k, 8'h5a ^ k[7:0]);
      wr(1'b0, k, 8'hc3 + k[7:0]);
    end
    find_z();
    chk_frames(24, lw[31:8], rw[31:8]);
    mute = 1'b1;
    chk_frames(3, 24'h0, 24'h0);
    mute = 1'b0;
    alone = 1'b1;
    cs_pin = 1'b1;
    user_pin = 1'b1;
    vbit = 1'b0;
    lw = 32'h00ff00ff;
    chk_frames(3, lw[31:8], rw[31:8]);
    alone = 1'b0;
    upin_sel = 1'b1;
    user_pin = 1'b0;
    chk_frames(3, lw[31:8], rw[31:8]);
    upin_sel = 1'b0;
    // Pin low now marks left, so the channels swap
    ws_pol = 1'b1;
    chk_frames(3, rw[31:8], lw[31:8]);
    ws_pol = 1'b0;
    just = 1'b1;
    chk_frames(3, lw[23:0], rw[23:0]);
    just = 1'b0;
    // The bit at the word select change is skipped
    dly = 1'b1;
    chk_frames(3, lw[30:7], rw[30:7]);
    dly = 1'b0;
    s_master(1'b0, 128);
    s_master(1'b1, 64);
    s_slip();
    dis = 1'b1;
    repeat (8) @(negedge sys_clk);
    low_for("disabled line");
    dis = 1'b0;
    clk_ok = 1'b0;
    repeat (20) @(negedge sys_clk);
    low_for("no clock line");
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    check("run time", 1'b0, 1'b1);
    report_and_stop();
  end
endmodule : tb_top
